/* logic/reset_seq_pkg.sv */
package reset_seq_pkg;

	// ----------------------------------------
	// Clock and pin timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS   = 100;
	localparam int PIN_LOW_MIN_NS  = 50;
	localparam int PIN_LOW_CYCLES_RAW = (PIN_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PIN_LOW_CYCLES  = (PIN_LOW_CYCLES_RAW < 1) ? 1 : PIN_LOW_CYCLES_RAW;
	localparam int SUPPLY_CYCLES   = 1;

	// ----------------------------------------
	// Start-up delay in watchdog oscillator ticks
	// ----------------------------------------
	localparam int SHORT_STARTUP_TICKS = 1024;
	localparam int LONG_STARTUP_TICKS  = 16384;
	localparam int TICK_CNT_W          = 15;

	// ----------------------------------------
	// Reset vector and flag layout
	// ----------------------------------------
	localparam int         FETCH_ADDR_W    = 12;
	localparam logic [11:0] RESET_VECTOR   = 12'h000;
	localparam int         FLAG_PIN_BIT    = 1;
	localparam int         FLAG_SUPPLY_BIT = 0;
	localparam logic [1:0] FLAGS_RESET     = 2'h0;

	typedef enum logic [1:0] {
		ST_HOLD,
		ST_COUNT,
		ST_RUN
	} seq_state_type;

endpackage

/* logic/level_qualifier.sv */
`timescale 1ns/10ps
// ----------------------------------------
// Two-flop synchroniser followed by a persistence filter
// ----------------------------------------
module level_qualifier #(
	parameter int HOLD_CYCLES = 1
) (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	// Level in and qualified level out
	input  wire logic level_i,
	output logic      qualified_o
);

	localparam int CNT_W = $clog2(HOLD_CYCLES + 1);

	logic             meta_ff;
	logic             sync_ff;
	logic [CNT_W-1:0] run_ff;
	logic [CNT_W-1:0] nxt_run;
	logic             qual_ff;
	logic             nxt_qual;

	generate
		if (HOLD_CYCLES < 1) begin : g_bad
			$error("level_qualifier: HOLD_CYCLES must be at least 1");
		end
	endgenerate

	// Level must persist the full time; drop is immediate
	always_comb begin
		nxt_run  = run_ff;
		nxt_qual = qual_ff;
		if (!sync_ff) begin
			nxt_run  = '0;
			nxt_qual = 1'b0;
		end else if (run_ff < CNT_W'(HOLD_CYCLES - 1)) begin
			nxt_run = run_ff + CNT_W'(1);
		end else begin
			nxt_qual = 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_ff <= 1'b0;
			sync_ff <= 1'b0;
			run_ff  <= '0;
			qual_ff <= 1'b0;
		end else begin
			meta_ff <= level_i;
			sync_ff <= meta_ff;
			run_ff  <= nxt_run;
			qual_ff <= nxt_qual;
		end
	end

	assign qualified_o = qual_ff;

endmodule

/* logic/reset_source_sequencer.sv */
`timescale 1ns/10ps
// How it works
// - Power-on, pin and watchdog expiry are the only sources; any one resets all.
// - Core stays reset while the supply detector reports supply below threshold.
// - Pin low longer than 50 ns is a reset; driver must hold that long.
// - Watchdog expiry resets only while the watchdog is enabled.
// - During reset I/O registers are initialised; fetch restarts at address zero.
// - Release delay counts oscillator ticks: 1K if short start-up, else 16K.
// - After power-on, the tick timer holds the core until the delay elapses.
// - Pin held low after power-on extends reset; counting starts at release.
// - Two sticky flags record pin and supply-low resets until software clears them; watchdog expiry sets neither.
module reset_source_sequencer #(
	parameter int SHORT_TICKS = reset_seq_pkg::SHORT_STARTUP_TICKS,
	parameter int LONG_TICKS  = reset_seq_pkg::LONG_STARTUP_TICKS
) (
	// Clock and reset
	input  wire logic                                   REF_CLK_I,
	input  wire logic                                   RESETN_I,
	// Reset sources
	input  wire logic                                   SUPPLY_LOW_I,
	input  wire logic                                   EXT_RESETN_I,
	input  wire logic                                   WDT_EXPIRE_I,
	input  wire logic                                   WDT_ENABLE_I,
	// Delay timebase and selection
	input  wire logic                                   WDT_OSC_TICK_I,
	input  wire logic                                   SHORT_STARTUP_SELECT_I,
	// Flag clear from software
	input  wire logic [1:0]                             FLAG_CLEAR_I,
	// Core control
	output logic                                        CORE_RESETN_O,
	output logic                                        IO_INIT_O,
	output logic [reset_seq_pkg::FETCH_ADDR_W-1:0]      FETCH_ADDR_O,
	// Reset source flags
	output logic                                        PIN_RESET_FLAG_O,
	output logic                                        SUPPLY_ON_RESET_FLAG_O
);

	localparam int CW = reset_seq_pkg::TICK_CNT_W;

	// ----------------------------------------
	// Parameter checks
	// ----------------------------------------
	generate
		if (SHORT_TICKS < 1 || LONG_TICKS < 1 || SHORT_TICKS > 2**CW || LONG_TICKS > 2**CW) begin : g_bad
			$error("reset_source_sequencer: tick counts out of range");
		end
		// Flag word is two bits, one per held source
		if (reset_seq_pkg::FLAG_PIN_BIT == reset_seq_pkg::FLAG_SUPPLY_BIT
			|| reset_seq_pkg::FLAG_PIN_BIT > 1 || reset_seq_pkg::FLAG_SUPPLY_BIT > 1) begin : g_flag_bits
			$error("reset_source_sequencer: flag bit positions invalid");
		end
		if ($bits(reset_seq_pkg::RESET_VECTOR) != reset_seq_pkg::FETCH_ADDR_W) begin : g_vector
			$error("reset_source_sequencer: reset vector width differs from fetch address");
		end
	endgenerate

	// ----------------------------------------
	// Source qualification
	// ----------------------------------------
	logic supply_low;
	logic pin_low;

	level_qualifier #(
		.HOLD_CYCLES (reset_seq_pkg::SUPPLY_CYCLES)
	) u_supply_q (
		.clk_i       (REF_CLK_I),
		.rst_n_i     (RESETN_I),
		.level_i     (SUPPLY_LOW_I),
		.qualified_o (supply_low)
	);

	level_qualifier #(
		.HOLD_CYCLES (reset_seq_pkg::PIN_LOW_CYCLES)
	) u_pin_q (
		.clk_i       (REF_CLK_I),
		.rst_n_i     (RESETN_I),
		.level_i     (~EXT_RESETN_I),
		.qualified_o (pin_low)
	);

	// ----------------------------------------
	// Settling after reset
	// ----------------------------------------
	// A held source needs the synchroniser and filter to show up; counting before
	// then could let an early tick release the core while the supply is still low
	localparam int SETTLE_CYCLES = 2 + ((reset_seq_pkg::SUPPLY_CYCLES > reset_seq_pkg::PIN_LOW_CYCLES) ?
		reset_seq_pkg::SUPPLY_CYCLES : reset_seq_pkg::PIN_LOW_CYCLES);
	localparam int SW            = $clog2(SETTLE_CYCLES + 1);

	logic [SW-1:0] settle_ff;
	logic [SW-1:0] nxt_settle;
	logic          settled;

	always_comb begin
		nxt_settle = settle_ff;
		if (settle_ff != SW'(SETTLE_CYCLES)) begin
			nxt_settle = settle_ff + SW'(1);
		end
	end

	always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			settle_ff <= '0;
		end else begin
			settle_ff <= nxt_settle;
		end
	end

	assign settled = (settle_ff == SW'(SETTLE_CYCLES));

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	reset_seq_pkg::seq_state_type state_ff;
	reset_seq_pkg::seq_state_type nxt_state;
	logic [CW-1:0]                tick_cnt_ff;
	logic [CW-1:0]                nxt_tick_cnt;
	logic [CW-1:0]                terminal_ff;
	logic [CW-1:0]                nxt_terminal;
	logic                         core_resetn_ff;
	logic                         nxt_core_resetn;
	logic                         io_init_ff;
	logic                         nxt_io_init;
	logic [reset_seq_pkg::FETCH_ADDR_W-1:0] fetch_addr_ff;
	logic                         wdt_hit;
	logic                         hold_req;

	// Expiry is already in this domain; a held expiry simply keeps restarting
	assign wdt_hit  = WDT_EXPIRE_I & WDT_ENABLE_I;
	assign hold_req = supply_low | pin_low | ~settled;

	always_comb begin
		nxt_state    = state_ff;
		nxt_tick_cnt = tick_cnt_ff;
		nxt_terminal = terminal_ff;
		case (state_ff)
			reset_seq_pkg::ST_HOLD: begin
				nxt_tick_cnt = '0;
				// Counting begins only on release of every held source
				if (!hold_req) begin
					nxt_state = reset_seq_pkg::ST_COUNT;
				end
			end
			reset_seq_pkg::ST_COUNT: begin
				if (WDT_OSC_TICK_I) begin
					nxt_tick_cnt = tick_cnt_ff + CW'(1);
				end
				// Ticks counted in full before release
				if (WDT_OSC_TICK_I && tick_cnt_ff == terminal_ff) begin
					nxt_state = reset_seq_pkg::ST_RUN;
				end
			end
			reset_seq_pkg::ST_RUN: begin
				nxt_tick_cnt = '0;
			end
			default: begin
				nxt_state = reset_seq_pkg::ST_HOLD;
			end
		endcase
		// Any source restarts the delay from zero
		if (hold_req) begin
			nxt_state    = reset_seq_pkg::ST_HOLD;
			nxt_tick_cnt = '0;
		end else if (wdt_hit) begin
			nxt_state    = reset_seq_pkg::ST_COUNT;
			nxt_tick_cnt = '0;
		end
		// Selection is latched at each restart so a change mid-count is harmless
		if (hold_req || wdt_hit || state_ff == reset_seq_pkg::ST_HOLD) begin
			nxt_terminal = SHORT_STARTUP_SELECT_I ? CW'(SHORT_TICKS - 1) : CW'(LONG_TICKS - 1);
		end
		nxt_core_resetn = (nxt_state == reset_seq_pkg::ST_RUN);
		nxt_io_init     = !nxt_core_resetn;
	end

	always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			state_ff       <= reset_seq_pkg::ST_HOLD;
			tick_cnt_ff    <= '0;
			terminal_ff    <= CW'(LONG_TICKS - 1);
			core_resetn_ff <= 1'b0;
			io_init_ff     <= 1'b1;
			fetch_addr_ff  <= reset_seq_pkg::RESET_VECTOR;
		end else begin
			state_ff       <= nxt_state;
			tick_cnt_ff    <= nxt_tick_cnt;
			terminal_ff    <= nxt_terminal;
			core_resetn_ff <= nxt_core_resetn;
			io_init_ff     <= nxt_io_init;
			fetch_addr_ff  <= reset_seq_pkg::RESET_VECTOR;
		end
	end

	// ----------------------------------------
	// Reset source flags
	// ----------------------------------------
	logic [1:0] flags_ff;
	logic [1:0] nxt_flags;

	// Set beats clear so a reset in the clear cycle is still recorded
	always_comb begin
		nxt_flags = flags_ff & ~FLAG_CLEAR_I;
		if (supply_low) begin
			nxt_flags[reset_seq_pkg::FLAG_SUPPLY_BIT] = 1'b1;
		end
		if (pin_low) begin
			nxt_flags[reset_seq_pkg::FLAG_PIN_BIT] = 1'b1;
		end
	end

	always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			flags_ff <= reset_seq_pkg::FLAGS_RESET;
		end else begin
			flags_ff <= nxt_flags;
		end
	end

	assign CORE_RESETN_O          = core_resetn_ff;
	assign IO_INIT_O              = io_init_ff;
	assign FETCH_ADDR_O           = fetch_addr_ff;
	assign PIN_RESET_FLAG_O       = flags_ff[reset_seq_pkg::FLAG_PIN_BIT];
	assign SUPPLY_ON_RESET_FLAG_O = flags_ff[reset_seq_pkg::FLAG_SUPPLY_BIT];

endmodule

/* bench/reset_seq_chk.sv */
`timescale 1ns/10ps
// ----
// Reset sequencing checks
// ----
module reset_seq_chk #(
	parameter int SHORT_TICKS = 1024,
	parameter int LONG_TICKS  = 16384
) (
	// Clock, reset, sources
	input wire logic        REF_CLK_I,
	input wire logic        RESETN_I,
	input wire logic        SUPPLY_LOW_I,
	input wire logic        EXT_RESETN_I,
	input wire logic        WDT_EXPIRE_I,
	input wire logic        WDT_ENABLE_I,
	input wire logic        WDT_OSC_TICK_I,
	input wire logic [1:0]  FLAG_CLEAR_I,
	// Outputs watched
	input wire logic        CORE_RESETN_O,
	input wire logic        IO_INIT_O,
	input wire logic [11:0] FETCH_ADDR_O,
	input wire logic        PIN_RESET_FLAG_O
);
	// Ticks seen while held; restarts only add, so an upper bound
	int tick_cnt_ff;
	int nxt_tick_cnt;
	always_comb begin
		nxt_tick_cnt = CORE_RESETN_O ? 0 : tick_cnt_ff + int'(WDT_OSC_TICK_I);
	end
	always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			tick_cnt_ff <= 0;
		end else begin
			tick_cnt_ff <= nxt_tick_cnt;
		end
	end
	default clocking @(posedge REF_CLK_I); endclocking
	default disable iff (!RESETN_I);
	a_io_init_mirror: assert property (IO_INIT_O == !CORE_RESETN_O) else $error("io init wrong");
	a_fetch_zero: assert property (FETCH_ADDR_O == 12'h000) else $error("fetch not zero");
	a_supply_holds: assert property (SUPPLY_LOW_I [*6] |-> !CORE_RESETN_O) else $error("supply low ignored");
	a_pin_holds: assert property (!EXT_RESETN_I [*6] |-> !CORE_RESETN_O) else $error("pin low ignored");
	a_wdt_reset: assert property (WDT_EXPIRE_I && WDT_ENABLE_I |=> !CORE_RESETN_O) else $error("no wdt reset");
	a_release_tick: assert property ($rose(CORE_RESETN_O) |-> $past(WDT_OSC_TICK_I)) else $error("off tick");
	a_delay_min: assert property ($rose(CORE_RESETN_O) |-> tick_cnt_ff >= SHORT_TICKS) else $error("early");
	a_pin_flag: assert property (!EXT_RESETN_I [*6] |-> PIN_RESET_FLAG_O) else $error("pin flag");
	a_flag_sticky: assert property (PIN_RESET_FLAG_O && !FLAG_CLEAR_I[1] |=> PIN_RESET_FLAG_O) else $error("lost");
	cover property ($rose(CORE_RESETN_O));
	cover property (WDT_EXPIRE_I && !WDT_ENABLE_I);
	cover property ($rose(PIN_RESET_FLAG_O));
endmodule
bind reset_source_sequencer reset_seq_chk #(.SHORT_TICKS(SHORT_TICKS), .LONG_TICKS(LONG_TICKS)) chk_inst (
	.REF_CLK_I(REF_CLK_I), .RESETN_I(RESETN_I), .SUPPLY_LOW_I(SUPPLY_LOW_I), .EXT_RESETN_I(EXT_RESETN_I),
	.WDT_EXPIRE_I(WDT_EXPIRE_I), .WDT_ENABLE_I(WDT_ENABLE_I), .WDT_OSC_TICK_I(WDT_OSC_TICK_I),
	.FLAG_CLEAR_I(FLAG_CLEAR_I), .CORE_RESETN_O(CORE_RESETN_O), .IO_INIT_O(IO_INIT_O),
	.FETCH_ADDR_O(FETCH_ADDR_O), .PIN_RESET_FLAG_O(PIN_RESET_FLAG_O));

/* bench/pin_supply_model.sv */
`timescale 1ns/10ps
// ----
// Supply monitor and reset pin driver
// ----
module pin_supply_model (
	// Clock
	input  wire logic clk_i,
	// Requests
	input  wire logic supply_req_i,
	input  wire logic pin_req_i,
	// Lines into the device
	output logic      supply_low_o = 1'b1,
	output logic      ext_resetn_o = 1'b0
);
	// Pulled up: a released pin reads high; held whole cycles, above the minimum
	always @(posedge clk_i) begin
		supply_low_o <= supply_req_i;
		ext_resetn_o <= ~pin_req_i;
	end
endmodule

/* bench/tb_reset_source_sequencer.sv */
`timescale 1ns/10ps
module tb_reset_source_sequencer;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        supply_req = 1'b1;
	logic        pin_req = 1'b1;
	logic        expire = 1'b0;
	logic        wdt_en = 1'b0;
	logic        tick = 1'b0;
	logic        short_sel = 1'b1;
	logic [1:0]  clr = 2'h0;
	logic        supply_low;
	logic        ext_resetn;
	logic        core_n;
	logic        io_init;
	logic        pin_flag;
	logic        sup_flag;
	logic [11:0] fetch;
	int          n_errors = 0;
	int          n_compared = 0;

	initial begin
		forever #50 clk = ~clk;
	end
	pin_supply_model pin_supply_model_inst (.clk_i(clk), .supply_req_i(supply_req), .pin_req_i(pin_req),
		.supply_low_o(supply_low), .ext_resetn_o(ext_resetn));
	reset_source_sequencer #(.SHORT_TICKS(4), .LONG_TICKS(16)) reset_source_sequencer_inst (
		.REF_CLK_I(clk), .RESETN_I(rst_n), .SUPPLY_LOW_I(supply_low), .EXT_RESETN_I(ext_resetn),
		.WDT_EXPIRE_I(expire), .WDT_ENABLE_I(wdt_en), .WDT_OSC_TICK_I(tick), .SHORT_STARTUP_SELECT_I(short_sel),
		.FLAG_CLEAR_I(clr), .CORE_RESETN_O(core_n), .IO_INIT_O(io_init), .FETCH_ADDR_O(fetch),
		.PIN_RESET_FLAG_O(pin_flag), .SUPPLY_ON_RESET_FLAG_O(sup_flag));

	task chk(input logic got, input logic exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t got %b expected %b", $time, got, exp);
		end
	endtask
	task chk_addr(input logic [11:0] got, input logic [11:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t address %h expected %h", $time, got, exp);
		end
	endtask
	task end_of_test();
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task tick_once();
		tick = 1'b1;
		cyc(1);
		tick = 1'b0;
		cyc(2);
	endtask
	task run_delay(input int t);
		for (int i = 0; i < t; i++) begin
			chk(core_n, 1'b0);
			tick_once();
		end
		chk(core_n, 1'b1);
		chk(io_init, 1'b0);
	endtask
	task pulse_expire();
		expire = 1'b1;
		cyc(1);
		expire = 1'b0;
	endtask
	task wait_low(input int n);
		for (int i = 0; i < n && core_n !== 1'b0; i++) cyc(1);
		if (core_n !== 1'b0) begin
			n_errors++;
			$display("[FAIL] %0t no core reset", $time);
			end_of_test();
		end
	endtask

	initial begin
		cyc(4);
		chk(io_init, 1'b1);
		chk_addr(fetch, 12'h000);
		chk(pin_flag, 1'b0);
		rst_n = 1'b1;
		cyc(8);
		supply_req = 1'b0;
		cyc(8);
		chk(core_n, 1'b0);
		chk(sup_flag, 1'b1);
		chk(pin_flag, 1'b1);
		pin_req = 1'b0;
		cyc(8);
		run_delay(4);
		chk_addr(fetch, 12'h000);
		clr = 2'h3;
		cyc(1);
		clr = 2'h0;
		chk(sup_flag, 1'b0);
		pulse_expire();
		cyc(2);
		chk(core_n, 1'b1);
		short_sel = 1'b0;
		wdt_en = 1'b1;
		pulse_expire();
		chk(core_n, 1'b0);
		run_delay(16);
		chk(pin_flag, 1'b0);
		short_sel = 1'b1;
		pin_req = 1'b1;
		cyc(1);
		pin_req = 1'b0;
		wait_low(8);
		chk(pin_flag, 1'b1);
		chk(sup_flag, 1'b0);
		cyc(8);
		tick_once();
		tick_once();
		pulse_expire();
		run_delay(4);
		end_of_test();
	end
endmodule
